// file: hw/pms_pkg.sv
// Package for the power mode sequencer: register map, field layout, mode codes, timing.
// Assumes a 200 MHz system clock and a byte-wide register port driven by the serial bus front end.
package pms_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_SYSTEM_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_EVENT_SUMMARY = 8'h11;
	localparam logic [7:0] ADDR_POWER_MODE = 8'hD2;
	localparam logic [7:0] ADDR_NORMAL_RATE = 8'hD3;
	localparam logic [7:0] ADDR_LOWPWR_RATE = 8'hD4;
	localparam logic [7:0] ADDR_SLEEP_RATE = 8'hD5;
	localparam logic [7:0] ADDR_MODE_TIMER = 8'hD6;
	localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'hD0;
	// Field positions
	localparam int BIT_SHOW_RESET = 7;
	localparam int BIT_SYSTEM_EVENT_FLAG = 5;
	localparam int BIT_ACK_RESET = 6;
	localparam int BIT_SLOW_OSC = 4;
	localparam int BIT_OTP_SLOW_OSC = 2;
	localparam int BIT_SLEEP_ALLOW = 6;
	localparam int BIT_AUTO_INHIBIT = 5;
	localparam int POS_FORCED_MODE = 3;
	localparam int POS_FRACTION = 0;
	// Reset values
	localparam logic [7:0] RST_POWER_MODE = 8'h00;
	localparam logic [7:0] RST_NORMAL_RATE = 8'h10;
	localparam logic [7:0] RST_LOWPWR_RATE = 8'h30;
	localparam logic [7:0] RST_SLEEP_RATE = 8'h08;
	localparam logic [7:0] RST_MODE_TIMER = 8'h14;
	localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h00;
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam int SLEEP_STEP_MS = 16;
	localparam int TIMER_STEP_MS = 500;
	localparam int OSC_FAST_MHZ = 16;
	localparam int OSC_SLOW_MHZ = 4;
	// Operating modes, Gray along normal -> low power -> deep sleep -> halt
	typedef enum logic [1:0]
	{
		PMS_NORMAL = 2'b00,
		PMS_LOWPWR = 2'b01,
		PMS_SLEEP = 2'b11,
		PMS_HALT = 2'b10
	} pms_mode_t;
	// Encoding in the forced mode field
	localparam logic [1:0] FM_NORMAL = 2'h0;
	localparam logic [1:0] FM_LOWPWR = 2'h1;
	localparam logic [1:0] FM_SLEEP = 2'h2;
	localparam logic [1:0] FM_HALT = 2'h3;
	// Register port request
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pms_req_t;
	// Sense scheduling outputs
	typedef struct packed
	{
		logic scanCh0;
		logic scanAll;
		logic slowOsc;
		pms_mode_t mode;
	} pms_sense_t;
endpackage

// file: hw/pms_sync.sv
// Two flip-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a slowly changing level; first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module pms_sync
(
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);
	logic meta_r;
	logic meta_nxt;
	logic hold_r;
	logic hold_nxt;

	// Next stage values
	always_comb
	begin
		meta_nxt = din;
		hold_nxt = meta_r;
	end

	// Registering only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= 1'b0;
			hold_r <= 1'b0;
		end
		else
		begin
			meta_r <= meta_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign dout = hold_r;
endmodule
`default_nettype wire

// file: hw/pms_ticker.sv
// Programmable period timer: pulses once per period of count base ticks.
// Assumes baseTick is a one-cycle pulse; a zero period fires on every base tick.
`timescale 1ns/100ps
`default_nettype none
module pms_ticker
#(
	parameter int W = 12
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic baseTick,
	input wire logic [W-1:0] period,
	output logic fire
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic fire_nxt;
	logic fire_r;

	// Count base ticks, fire when the period is reached
	always_comb
	begin
		cnt_nxt = cnt_r;
		fire_nxt = 1'b0;
		if (restart)
			cnt_nxt = '0;
		else if (baseTick)
		begin
			if (cnt_r + W'(1) >= period)
			begin
				cnt_nxt = '0;
				fire_nxt = 1'b1;
			end
			else
				cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			fire_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			fire_r <= fire_nxt;
		end
	end

	assign fire = fire_r;
endmodule
`default_nettype wire

// file: hw/power_mode_sequencer.sv
// Power mode sequencer: oscillator speed, mode control, sense scheduling, reset indication.
// Assumes a serial bus front end presents byte register accesses on the req port in the clk domain.
// Operation
// - System logic on 16MHz oscillator, 4MHz option
// - Slow oscillator keeps timer rates, quarters transfer
// - Control bit 4 selects slow oscillator
// - OTP bank0 bit 2 forces slow oscillator
// - Four modes: normal, low, deep sleep, halt
// - Auto switching unless inhibit bit 5 set
// - Inhibited: mode from field bits 4-3
// - Normal period from 0xD3 in 1ms steps
// - Low power period from 0xD4, slow oscillator
// - Deep sleep scans channel 0 only, plus full updates
// - Full update fraction from bits 2-0
// - Deep sleep allowed only with bit 6
// - Deep sleep period 0xD5 times 16ms
// - Channel 0 proximity wakes to normal
// - Halt suspends sensing until mode write; a write that clears the inhibit keeps halt until the next write
// - Inactivity timer 0xD6 in 500ms steps
// - Show reset flag cleared by acknowledge bit
// - System event reasserted until reset acknowledged
`timescale 1ns/100ps
`default_nettype none
module power_mode_sequencer
#(
	parameter int TICK_LEN = pms_pkg::TICK_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire pms_pkg::pms_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic otpSlowOsc,
	input wire logic prox0Pin,
	input wire logic activityPin,
	output pms_pkg::pms_sense_t sense
);
	localparam int SLEEP_W = 12;
	localparam int TIMER_W = 17;

	// Register file
	logic [7:0] powerMode_r, powerMode_nxt;
	logic [7:0] normalRate_r, normalRate_nxt;
	logic [7:0] lowRate_r, lowRate_nxt;
	logic [7:0] sleepRate_r, sleepRate_nxt;
	logic [7:0] modeTimer_r, modeTimer_nxt;
	logic [7:0] sysCtl_r, sysCtl_nxt;
	logic showReset_r, showReset_nxt;
	logic sysEvent_r, sysEvent_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	// Mode state
	pms_pkg::pms_mode_t mode_r, mode_nxt;
	logic [8:0] frac_r, frac_nxt;
	logic otpSlow_r, otpSlow_nxt;
	logic strapDone_r, strapDone_nxt;
	// Millisecond base
	logic [31:0] div_r, div_nxt;
	logic msTick_r, msTick_nxt;

	logic prox0;
	logic activity;
	logic otpSync;
	logic slowOsc;
	logic autoOn;
	logic [1:0] forced;
	logic [SLEEP_W-1:0] sleepPeriod;
	logic [TIMER_W-1:0] idlePeriod;
	logic [7:0] curPeriod;
	logic senseFire;
	logic sleepFire;
	logic idleFire;
	logic modeWrite;
	logic [8:0] fracLimit;

	pms_sync u_syncProx
	(
		.clk(clk),
		.rst(rst),
		.din(prox0Pin),
		.dout(prox0)
	);
	pms_sync u_syncAct
	(
		.clk(clk),
		.rst(rst),
		.din(activityPin),
		.dout(activity)
	);
	pms_sync u_syncOtp
	(
		.clk(clk),
		.rst(1'b0), // Runs through reset so the strap has settled at release
		.din(otpSlowOsc),
		.dout(otpSync)
	);

	// Map forced field onto the mode type
	function automatic pms_pkg::pms_mode_t decode_mode(input logic [1:0] f);
		case (f)
			pms_pkg::FM_NORMAL: decode_mode = pms_pkg::PMS_NORMAL;
			pms_pkg::FM_LOWPWR: decode_mode = pms_pkg::PMS_LOWPWR;
			pms_pkg::FM_SLEEP: decode_mode = pms_pkg::PMS_SLEEP;
			default: decode_mode = pms_pkg::PMS_HALT;
		endcase
	endfunction

	assign autoOn = ~powerMode_r[pms_pkg::BIT_AUTO_INHIBIT];
	assign forced = powerMode_r[pms_pkg::POS_FORCED_MODE +: 2];
	assign slowOsc = sysCtl_r[pms_pkg::BIT_SLOW_OSC] | otpSlow_r;
	assign modeWrite = req.wr && req.addr == pms_pkg::ADDR_POWER_MODE;
	// One full update every 2^(n+1) deep sleep periods
	assign fracLimit = 9'(9'h002 << powerMode_r[pms_pkg::POS_FRACTION +: 3]);
	assign sleepPeriod = SLEEP_W'(sleepRate_r) * SLEEP_W'(pms_pkg::SLEEP_STEP_MS);
	assign idlePeriod = TIMER_W'(modeTimer_r) * TIMER_W'(pms_pkg::TIMER_STEP_MS);
	assign curPeriod = (mode_r == pms_pkg::PMS_LOWPWR) ? lowRate_r : normalRate_r;

	// Timers count real milliseconds whatever the oscillator speed, so rates hold
	always_comb
	begin
		div_nxt = div_r + 32'h1;
		msTick_nxt = 1'b0;
		if (div_r >= 32'(TICK_LEN - 1))
		begin
			div_nxt = 32'h0;
			msTick_nxt = 1'b1;
		end
	end

	pms_ticker #(.W(8)) u_senseTick
	(
		.clk(clk),
		.rst(rst),
		.restart(mode_r != mode_nxt),
		.baseTick(msTick_r && (mode_r == pms_pkg::PMS_NORMAL || mode_r == pms_pkg::PMS_LOWPWR)),
		.period(curPeriod),
		.fire(senseFire)
	);
	pms_ticker #(.W(SLEEP_W)) u_sleepTick
	(
		.clk(clk),
		.rst(rst),
		.restart(mode_r != pms_pkg::PMS_SLEEP),
		.baseTick(msTick_r),
		.period(sleepPeriod),
		.fire(sleepFire)
	);
	pms_ticker #(.W(TIMER_W)) u_idleTick
	(
		.clk(clk),
		.rst(rst),
		.restart(activity || mode_r != mode_nxt || !autoOn),
		.baseTick(msTick_r),
		.period(idlePeriod),
		.fire(idleFire)
	);

	// Register writes and flag upkeep
	always_comb
	begin
		powerMode_nxt = powerMode_r;
		normalRate_nxt = normalRate_r;
		lowRate_nxt = lowRate_r;
		sleepRate_nxt = sleepRate_r;
		modeTimer_nxt = modeTimer_r;
		sysCtl_nxt = sysCtl_r;
		showReset_nxt = showReset_r;
		if (req.wr)
		begin
			case (req.addr)
				pms_pkg::ADDR_POWER_MODE: powerMode_nxt = req.wdata;
				pms_pkg::ADDR_NORMAL_RATE: normalRate_nxt = req.wdata;
				pms_pkg::ADDR_LOWPWR_RATE: lowRate_nxt = req.wdata;
				pms_pkg::ADDR_SLEEP_RATE: sleepRate_nxt = req.wdata;
				pms_pkg::ADDR_MODE_TIMER: modeTimer_nxt = req.wdata;
				pms_pkg::ADDR_SYSTEM_CONTROL:
				begin
					sysCtl_nxt = req.wdata;
					sysCtl_nxt[pms_pkg::BIT_ACK_RESET] = 1'b0; // Acknowledge is self clearing
					if (req.wdata[pms_pkg::BIT_ACK_RESET])
						showReset_nxt = 1'b0;
				end
				default: ;
			endcase
		end
		// Event summary follows the unacknowledged reset
		sysEvent_nxt = showReset_nxt;
	end

	// Read path, unmapped addresses return zero
	always_comb
	begin
		rdata_nxt = rdata_r;
		rvalid_nxt = req.rd;
		if (req.rd)
		begin
			case (req.addr)
				pms_pkg::ADDR_SYSTEM_FLAGS: rdata_nxt = 8'(showReset_r) << pms_pkg::BIT_SHOW_RESET;
				pms_pkg::ADDR_EVENT_SUMMARY: rdata_nxt = 8'(sysEvent_r) << pms_pkg::BIT_SYSTEM_EVENT_FLAG;
				pms_pkg::ADDR_POWER_MODE: rdata_nxt = powerMode_r;
				pms_pkg::ADDR_NORMAL_RATE: rdata_nxt = normalRate_r;
				pms_pkg::ADDR_LOWPWR_RATE: rdata_nxt = lowRate_r;
				pms_pkg::ADDR_SLEEP_RATE: rdata_nxt = sleepRate_r;
				pms_pkg::ADDR_MODE_TIMER: rdata_nxt = modeTimer_r;
				pms_pkg::ADDR_SYSTEM_CONTROL: rdata_nxt = sysCtl_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Mode sequencing
	always_comb
	begin
		mode_nxt = mode_r;
		frac_nxt = frac_r;
		otpSlow_nxt = otpSlow_r;
		strapDone_nxt = 1'b1;
		if (!strapDone_r)
			otpSlow_nxt = otpSync; // Strap caught once after reset release
		if (!autoOn)
		begin
			// Forced mode; halt is left only by a new mode write
			mode_nxt = decode_mode(forced);
			if (mode_nxt == pms_pkg::PMS_SLEEP && !powerMode_r[pms_pkg::BIT_SLEEP_ALLOW])
				mode_nxt = pms_pkg::PMS_LOWPWR;
		end
		else
		begin
			case (mode_r)
				pms_pkg::PMS_NORMAL:
					if (idleFire)
						mode_nxt = pms_pkg::PMS_LOWPWR;
				pms_pkg::PMS_LOWPWR:
					if (idleFire && powerMode_r[pms_pkg::BIT_SLEEP_ALLOW])
						mode_nxt = pms_pkg::PMS_SLEEP;
				pms_pkg::PMS_SLEEP:
					if (prox0 || !powerMode_r[pms_pkg::BIT_SLEEP_ALLOW])
						mode_nxt = pms_pkg::PMS_NORMAL;
				pms_pkg::PMS_HALT:
					if (modeWrite)
						mode_nxt = pms_pkg::PMS_NORMAL;
				default: mode_nxt = pms_pkg::PMS_NORMAL;
			endcase
		end
		if (sleepFire)
			frac_nxt = (frac_r + 9'h001 >= fracLimit) ? 9'h000 : frac_r + 9'h001;
		if (mode_r != pms_pkg::PMS_SLEEP)
			frac_nxt = 9'h000;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			powerMode_r <= pms_pkg::RST_POWER_MODE;
			normalRate_r <= pms_pkg::RST_NORMAL_RATE;
			lowRate_r <= pms_pkg::RST_LOWPWR_RATE;
			sleepRate_r <= pms_pkg::RST_SLEEP_RATE;
			modeTimer_r <= pms_pkg::RST_MODE_TIMER;
			sysCtl_r <= pms_pkg::RST_SYSTEM_CONTROL;
			showReset_r <= 1'b1;
			sysEvent_r <= 1'b1;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			mode_r <= pms_pkg::PMS_NORMAL;
			frac_r <= 9'h000;
			otpSlow_r <= 1'b0;
			strapDone_r <= 1'b0;
			div_r <= 32'h0;
			msTick_r <= 1'b0;
		end
		else
		begin
			powerMode_r <= powerMode_nxt;
			normalRate_r <= normalRate_nxt;
			lowRate_r <= lowRate_nxt;
			sleepRate_r <= sleepRate_nxt;
			modeTimer_r <= modeTimer_nxt;
			sysCtl_r <= sysCtl_nxt;
			showReset_r <= showReset_nxt;
			sysEvent_r <= sysEvent_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			mode_r <= mode_nxt;
			frac_r <= frac_nxt;
			otpSlow_r <= otpSlow_nxt;
			strapDone_r <= strapDone_nxt;
			div_r <= div_nxt;
			msTick_r <= msTick_nxt;
		end
	end

	// Sense requests; halt also masks a pulse launched in the cycle before it
	always_comb
	begin
		sense.mode = mode_r;
		sense.slowOsc = slowOsc || mode_r == pms_pkg::PMS_LOWPWR;
		sense.scanAll = (senseFire || (sleepFire && frac_r == 9'h000)) && mode_r != pms_pkg::PMS_HALT;
		sense.scanCh0 = (senseFire || sleepFire) && mode_r != pms_pkg::PMS_HALT;
	end
	assign rdata = rdata_r;
	assign rvalid = rvalid_r;

	// Checks
	property p_ackClears;
		@(posedge clk) disable iff (rst)
		req.wr && req.addr == pms_pkg::ADDR_SYSTEM_CONTROL && req.wdata[pms_pkg::BIT_ACK_RESET] |=> !showReset_r;
	endproperty
	a_ackClears: assert property (p_ackClears) else $error("reset flag not cleared");
	property p_eventFollows;
		@(posedge clk) disable iff (rst) showReset_r |-> sysEvent_r;
	endproperty
	a_eventFollows: assert property (p_eventFollows) else $error("event dropped early");
	property p_forced;
		@(posedge clk) disable iff (rst)
		(!autoOn && forced == pms_pkg::FM_HALT) ##1 (!autoOn && forced == pms_pkg::FM_HALT) |-> mode_r == pms_pkg::PMS_HALT;
	endproperty
	a_forced: assert property (p_forced) else $error("forced mode not followed");
	property p_haltQuiet;
		@(posedge clk) disable iff (rst) mode_r == pms_pkg::PMS_HALT |-> !sense.scanCh0 && !sense.scanAll;
	endproperty
	a_haltQuiet: assert property (p_haltQuiet) else $error("sensing in halt");
	property p_sleepGate;
		@(posedge clk) disable iff (rst) mode_r == pms_pkg::PMS_SLEEP |-> $past(powerMode_r[pms_pkg::BIT_SLEEP_ALLOW]);
	endproperty
	a_sleepGate: assert property (p_sleepGate) else $error("sleep without allow");
	property p_wake;
		@(posedge clk) disable iff (rst) autoOn && mode_r == pms_pkg::PMS_SLEEP && prox0 |=> mode_r == pms_pkg::PMS_NORMAL;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on proximity");
	property p_idleStep;
		@(posedge clk) disable iff (rst) autoOn && mode_r == pms_pkg::PMS_NORMAL && idleFire |=> mode_r == pms_pkg::PMS_LOWPWR;
	endproperty
	a_idleStep: assert property (p_idleStep) else $error("no step on inactivity");
	property p_slowOsc;
		@(posedge clk) disable iff (rst) sysCtl_r[pms_pkg::BIT_SLOW_OSC] |-> sense.slowOsc;
	endproperty
	a_slowOsc: assert property (p_slowOsc) else $error("slow oscillator not selected");
endmodule
`default_nettype wire

// file: tb/pms_host_model.sv
// Host model: issues single-byte register writes and reads on the request port.
// Assumes the bench clock; every request changes 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module pms_host_model
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output var pms_pkg::pms_req_t req
);
	// Idle request until a task runs
	initial req = '0;

	// Write strobe stands for exactly one taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge clk);
		#1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		#1 req = '0;
	end
	endtask

	// Read data is taken while the one-cycle valid pulse stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		int k;
	begin
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk);
		#1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		for (k = 0; k < 4 && !ok; k++)
		begin
			@(posedge clk);
			#1 req = '0;
			if (rvalid === 1'b1)
			begin
				ok = 1'b1;
				d = rdata;
			end
		end
	end
	endtask
endmodule
`default_nettype wire

// file: tb/power_mode_sequencer_tb.sv
// Self-checking bench for the power mode sequencer.
// Assumes the host model drives the request port; TICK_LEN is cut to 4 cycles per ms.
`timescale 1ns/100ps
`default_nettype none
module power_mode_sequencer_tb;
	typedef struct packed
	{
		logic isWr;
		logic [7:0] addr;
		logic [7:0] data;
	} pms_row_t;
	localparam int TL = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic otpSlowOsc = 1'b0;
	logic prox0Pin = 1'b0;
	logic activityPin = 1'b1;
	logic [7:0] rdata;
	logic rvalid;
	pms_pkg::pms_req_t req;
	pms_pkg::pms_sense_t sense;
	int error_cnt = 0;
	int n_compared = 0;
	pms_row_t rows [12];
	pms_pkg::pms_mode_t modeTab [4];

	// Bench clock, 5 ns period
	always #2.5 clk = ~clk;

	pms_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
	power_mode_sequencer #(.TICK_LEN(TL)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.rvalid(rvalid), .otpSlowOsc(otpSlowOsc), .prox0Pin(prox0Pin), .activityPin(activityPin),
		.sense(sense));

	// Verdict and end of run
	task automatic report_and_stop;
	begin
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic chkMode(input pms_pkg::pms_mode_t got, input pms_pkg::pms_mode_t exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	end
	endtask

	// A used-up wait counts as a mismatch and ends the run
	task automatic hang;
	begin
		chk(16'h0000, 16'h0001);
		report_and_stop();
	end
	endtask

	// Leaves the bench 1 ns after an edge, where outputs have settled
	task automatic cyc(input int n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask

	task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
		bit ok;
	begin
		host.rd(a, d, ok);
		if (!ok)
			hang();
	end
	endtask

	task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
	begin
		rdReg(a, d);
		chk({8'h00, d}, {8'h00, exp});
	end
	endtask

	// Cycles between two successive pulses of one scan output
	task automatic gap(input bit all, output int n);
		int k;
	begin
		n = -1;
		for (k = 0; k < 1200; k++)
		begin
			cyc(1);
			if (n >= 0)
				n++;
			if ((all ? sense.scanAll : sense.scanCh0) === 1'b1)
			begin
				if (n > 0)
					return;
				n = 0;
			end
		end
		hang();
	end
	endtask

	// The first gap after a mode change may be short, so the second is judged
	task automatic period(input logic [7:0] a, input logic [7:0] v, input logic [7:0] pm, input bit all,
		input int exp);
		int n;
	begin
		host.wr(a, v);
		host.wr(8'hD2, pm);
		gap(all, n);
		gap(all, n);
		chk(n[15:0], exp[15:0]);
	end
	endtask

	task automatic waitMode(input pms_pkg::pms_mode_t from, input int lim);
		int n;
	begin
		n = 0;
		while (sense.mode === from)
		begin
			if (n >= lim)
				hang();
			cyc(1);
			n++;
		end
	end
	endtask

	// Main sequence: reset flag checks first, then the table rows, then the hand-written cases
	initial
	begin
		int k;
		int n;
		logic [7:0] d;
		modeTab = '{pms_pkg::PMS_NORMAL, pms_pkg::PMS_LOWPWR, pms_pkg::PMS_SLEEP, pms_pkg::PMS_HALT};
		rows = '{'{1'b0, 8'hD2, 8'h00}, '{1'b0, 8'hD3, 8'h10}, '{1'b0, 8'hD4, 8'h30},
			'{1'b0, 8'hD5, 8'h08}, '{1'b0, 8'hD6, 8'h14}, '{1'b0, 8'h55, 8'h00},
			'{1'b1, 8'h10, 8'h00}, '{1'b0, 8'h10, 8'h80}, '{1'b1, 8'h55, 8'hAA},
			'{1'b0, 8'h55, 8'h00}, '{1'b1, 8'hD5, 8'hC3}, '{1'b0, 8'hD5, 8'hC3}};
		cyc(8);
		rst = 1'b0;
		chkReg(8'h10, 8'h80);
		rdReg(8'h11, d);
		chk({15'h0000, d[5]}, 16'h0001);
		chk({15'h0000, sense.slowOsc}, 16'h0000);
		for (k = 0; k < 12; k++)
		begin
			if (rows[k].isWr)
				host.wr(rows[k].addr, rows[k].data);
			else
				chkReg(rows[k].addr, rows[k].data);
		end
		rdReg(8'h11, d);
		chk({15'h0000, d[5]}, 16'h0001);
		$display("test registers done");
		host.wr(8'hD0, 8'h40);
		chkReg(8'h10, 8'h00);
		rdReg(8'h11, d);
		chk({15'h0000, d[5]}, 16'h0000);
		chkReg(8'hD0, 8'h00);
		host.wr(8'hD0, 8'h10);
		cyc(2);
		chk({15'h0000, sense.slowOsc}, 16'h0001);
		host.wr(8'hD0, 8'h00);
		cyc(2);
		chk({15'h0000, sense.slowOsc}, 16'h0000);
		$display("test acknowledge and oscillator done");
		// Inhibit bit set in every write, so halt is entered and left under it
		for (k = 0; k < 4; k++)
		begin
			host.wr(8'hD2, 8'h60 | (k[7:0] << 3));
			cyc(2);
			chkMode(sense.mode, modeTab[k]);
		end
		n = 0;
		for (k = 0; k < 300; k++)
		begin
			cyc(1);
			n += (sense.scanCh0 === 1'b1 || sense.scanAll === 1'b1) ? 1 : 0;
		end
		chk(n[15:0], 16'h0000);
		host.wr(8'hD2, 8'h60);
		cyc(2);
		chkMode(sense.mode, pms_pkg::PMS_NORMAL);
		host.wr(8'hD2, 8'h30);
		cyc(2);
		chkMode(sense.mode, pms_pkg::PMS_LOWPWR);
		$display("test forced modes done");
		period(8'hD3, 8'h00, 8'h60, 1'b0, TL);
		period(8'hD3, 8'h02, 8'h60, 1'b0, 2 * TL);
		period(8'hD4, 8'h03, 8'h68, 1'b0, 3 * TL);
		period(8'hD5, 8'h01, 8'h71, 1'b0, 16 * TL);
		period(8'hD5, 8'h01, 8'h71, 1'b1, 64 * TL);
		$display("test periods done");
		// Leave deep sleep under the inhibit first; auto mode alone would stay there
		host.wr(8'hD2, 8'h60);
		host.wr(8'hD6, 8'h01);
		host.wr(8'hD2, 8'h40);
		cyc(5000);
		chkMode(sense.mode, pms_pkg::PMS_NORMAL);
		activityPin = 1'b0;
		waitMode(pms_pkg::PMS_NORMAL, 1100 * TL);
		chkMode(sense.mode, pms_pkg::PMS_LOWPWR);
		waitMode(pms_pkg::PMS_LOWPWR, 1100 * TL);
		chkMode(sense.mode, pms_pkg::PMS_SLEEP);
		prox0Pin = 1'b1;
		waitMode(pms_pkg::PMS_SLEEP, 8);
		chkMode(sense.mode, pms_pkg::PMS_NORMAL);
		prox0Pin = 1'b0;
		activityPin = 1'b1;
		$display("test automatic modes done");
		// Strap held from before reset so the synchroniser sees it at release
		otpSlowOsc = 1'b1;
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		cyc(2);
		chk({15'h0000, sense.slowOsc}, 16'h0001);
		chkReg(8'h10, 8'h80);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
